// File: hdl/serial_line_buffer.sv
// Purpose: Serial line buffer of 5048 bytes with internal write and read pointers.
// Assumes: Pin clocks are much slower than ref_clk_in and are sampled as ordinary inputs.
// Notes:   Each pin passes two flip-flops; a third stage gives the clock edges.
`timescale 1ns/100ps
`default_nettype none
`include "line_buffer_params.svh"

module serial_line_buffer
  import line_buffer_pkg::*;
#(
  parameter int DATA_W = `LB_DATA_W
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              write_clock_in,
  input  wire logic              write_side_enable_n_in,
  input  wire logic              write_pointer_clear_n_in,
  input  wire logic [DATA_W-1:0] write_data_in,
  input  wire logic              read_clock_in,
  input  wire logic              output_side_enable_n_in,
  input  wire logic              read_pointer_clear_n_in,
  output logic      [DATA_W-1:0] read_data_out,
  output logic                   read_data_oe_n_out,
  output logic                   read_data_valid_out,
  input  wire logic              read_data_ready_in
);

  core_s core_ff;
  core_s nxt_core;
  byte_t mem [`LB_LOC_COUNT];
  pin_s  pins;
  logic  w_edge;
  logic  r_edge;
  logic  w_go;
  logic  r_go;
  ptr_t  waddr;
  ptr_t  raddr;
  logic  buf_ready;

  // One step forward with wrap, shared by both ports.
  function automatic ptr_t next_loc(input ptr_t p);
    next_loc = (p == `LB_LOC_LAST) ? `LB_LOC_ZERO : ptr_t'(p + `LB_PTR_STEP);
  endfunction

  // Clear wins over stepping: address 0 is used while clear is low.
  function automatic ptr_t cycle_loc(input ptr_t p, input logic clr_n);
    cycle_loc = clr_n ? next_loc(p) : `LB_LOC_ZERO;
  endfunction

  // Clock pins travel with their qualifiers, so one sample sees a consistent set.
  always_comb begin
    pins.wclk   = write_clock_in;
    pins.we_n   = write_side_enable_n_in;
    pins.wclr_n = write_pointer_clear_n_in;
    pins.rclk   = read_clock_in;
    pins.rden_n = output_side_enable_n_in;
    pins.rclr_n = read_pointer_clear_n_in;
    pins.wdata  = write_data_in;
  end

  assign w_edge = core_ff.s2.wclk & ~core_ff.wclk_q;
  assign r_edge = core_ff.s2.rclk & ~core_ff.rclk_q;
  assign w_go   = w_edge & ~core_ff.s2.we_n;
  // A full output buffer drops the read cycle; the read pointer holds and no byte is taken.
  assign r_go   = r_edge & ~core_ff.s2.rden_n & buf_ready;
  assign waddr  = cycle_loc(core_ff.wptr, core_ff.s2.wclr_n);
  assign raddr  = cycle_loc(core_ff.rptr, core_ff.s2.rclr_n);

  always_comb begin
    nxt_core        = core_ff;
    // Only the second stage feeds logic; the third exists solely to find rising edges.
    nxt_core.s1     = pins;
    nxt_core.s2     = core_ff.s1;
    nxt_core.wclk_q = core_ff.s2.wclk;
    nxt_core.rclk_q = core_ff.s2.rclk;
    nxt_core.oe_n   = core_ff.s2.rden_n;
    if (w_go) begin
      nxt_core.wptr = waddr;
    end
    if (r_go) begin
      nxt_core.rptr = raddr;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_ff      <= '0;
      core_ff.s1   <= pin_s'(`LB_SYNC_RST);
      core_ff.s2   <= pin_s'(`LB_SYNC_RST);
      // Pointers start on the last location so the first unclear cycle lands on 0.
      core_ff.wptr <= `LB_PTR_RST;
      core_ff.rptr <= `LB_PTR_RST;
      core_ff.oe_n <= 1'b1;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // Storage has no reset; its contents are undefined until written.
  always_ff @(posedge ref_clk_in) begin
    if (w_go) begin
      mem[waddr] <= core_ff.s2.wdata;
    end
  end

  // No fill level leaves this block; pacing the reader is up to its users.
  word_buffer2 #(
    .WIDTH(DATA_W)
  ) word_buffer2_i (
    .clk_in        (ref_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (r_go),
    .in_ready_out  (buf_ready),
    .in_data_in    (mem[raddr]),
    .out_valid_out (read_data_valid_out),
    .out_ready_in  (read_data_ready_in),
    .out_data_out  (read_data_out)
  );

  assign read_data_oe_n_out = core_ff.oe_n;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Clears.
  chk_wclr_zero: assert property (
    w_go && !core_ff.s2.wclr_n |=> core_ff.wptr == '0)
    else $error("write pointer not at zero after clear");
  chk_rclr_zero: assert property (
    r_go && !core_ff.s2.rclr_n |=> core_ff.rptr == '0)
    else $error("read pointer not at zero after clear");
  chk_wclr_addr: assert property (
    w_go && !core_ff.s2.wclr_n |-> waddr == '0)
    else $error("write clear does not address location zero");
  chk_delay_align: assert property (
    w_go && r_go && !core_ff.s2.wclr_n && !core_ff.s2.rclr_n |=> core_ff.wptr == core_ff.rptr)
    else $error("pointers apart after a joint clear");

  // Pointer motion.
  chk_wptr_hold: assert property (
    !w_go |=> $stable(core_ff.wptr))
    else $error("write pointer moved without a write cycle");
  chk_rptr_hold: assert property (
    !r_go |=> $stable(core_ff.rptr))
    else $error("read pointer moved without a read cycle");
  chk_wptr_wrap: assert property (
    w_go && core_ff.s2.wclr_n && core_ff.wptr == `LB_LOC_LAST |=> core_ff.wptr == '0)
    else $error("write pointer did not wrap to zero");
  chk_rptr_wrap: assert property (
    r_go && core_ff.s2.rclr_n && core_ff.rptr == `LB_LOC_LAST |=> core_ff.rptr == '0)
    else $error("read pointer did not wrap to zero");
  chk_wptr_step: assert property (
    w_go && core_ff.s2.wclr_n && core_ff.wptr != `LB_LOC_LAST
    |=> core_ff.wptr == $past(core_ff.wptr) + `LB_PTR_STEP)
    else $error("write pointer did not step by one");
  chk_rptr_step: assert property (
    r_go && core_ff.s2.rclr_n && core_ff.rptr != `LB_LOC_LAST
    |=> core_ff.rptr == $past(core_ff.rptr) + `LB_PTR_STEP)
    else $error("read pointer did not step by one");
  chk_wptr_range: assert property (
    core_ff.wptr <= `LB_LOC_LAST)
    else $error("write pointer outside the storage");
  chk_rptr_range: assert property (
    core_ff.rptr <= `LB_LOC_LAST)
    else $error("read pointer outside the storage");
  chk_w_edge_once: assert property (
    w_edge |=> !w_edge)
    else $error("one write clock edge seen twice");
  chk_r_edge_once: assert property (
    r_edge |=> !r_edge)
    else $error("one read clock edge seen twice");

  // Storage and output stream.
  chk_write_zero: assert property (
    w_go && !core_ff.s2.wclr_n |=> mem[0] == $past(core_ff.s2.wdata))
    else $error("clear cycle byte not stored at location zero");
  chk_wdata_store: assert property (
    w_go |=> mem[$past(waddr)] == $past(core_ff.s2.wdata))
    else $error("write byte not stored at its location");
  chk_read_zero: assert property (
    r_go && !core_ff.s2.rclr_n |-> raddr == '0)
    else $error("read clear does not address location zero");
  chk_push_head: assert property (
    r_go && !read_data_valid_out |=> read_data_valid_out && read_data_out == $past(mem[raddr]))
    else $error("read byte not presented after its cycle");
  chk_valid_follow: assert property (
    r_go |=> read_data_valid_out)
    else $error("read cycle produced no byte");
  chk_out_stand: assert property (
    read_data_valid_out && !read_data_ready_in |=> read_data_valid_out && $stable(read_data_out))
    else $error("output byte changed while stalled");

  // Output enable.
  chk_oe_follow: assert property (
    core_ff.s2.rden_n |=> read_data_oe_n_out)
    else $error("data pins driven while read disabled");
  chk_oe_drive: assert property (
    !core_ff.s2.rden_n |=> !read_data_oe_n_out)
    else $error("data pins float while read enabled");

  // Main scenarios.
  cov_write_clear: cover property (
    w_go && !core_ff.s2.wclr_n ##[1:40] w_go && core_ff.s2.wclr_n);
  cov_read_wrap:   cover property (r_go && core_ff.rptr == `LB_LOC_LAST);
  cov_write_wrap:  cover property (w_go && core_ff.s2.wclr_n && core_ff.wptr == `LB_LOC_LAST);
  cov_out_stall:   cover property (r_edge && !core_ff.s2.rden_n && !buf_ready);
  cov_delay_line:  cover property (w_go && r_go && !core_ff.s2.wclr_n && !core_ff.s2.rclr_n);

endmodule // serial_line_buffer

`default_nettype wire

// File: hdl/line_buffer_params.svh
// Purpose: Constants for the serial line buffer.
// Assumes: Included by bare name from the package and the design files.
// Notes:   Locations count from 0 up to LB_LOC_LAST, then wrap to 0.
`ifndef LINE_BUFFER_PARAMS_SVH
`define LINE_BUFFER_PARAMS_SVH

`define LB_LOC_COUNT 5048
`define LB_PTR_W     13
`define LB_DATA_W    8
`define LB_LOC_LAST  13'h13b7
`define LB_LOC_ZERO  13'h0000
`define LB_PTR_STEP  13'h0001
`define LB_PTR_RST   13'h13b7
`define LB_SYNC_RST  14'h1b00

`endif

// File: hdl/line_buffer_pkg.sv
// Purpose: Types shared by the serial line buffer files.
// Assumes: line_buffer_params.svh gives the widths.
// Notes:   Pin groups travel as one packed struct through the synchroniser.
`include "line_buffer_params.svh"

package line_buffer_pkg;

  typedef logic [`LB_PTR_W-1:0]  ptr_t;
  typedef logic [`LB_DATA_W-1:0] byte_t;

  typedef struct packed {
    logic  wclk;
    logic  we_n;
    logic  wclr_n;
    logic  rclk;
    logic  rden_n;
    logic  rclr_n;
    byte_t wdata;
  } pin_s;

  typedef struct packed {
    pin_s  s1;
    pin_s  s2;
    logic  wclk_q;
    logic  rclk_q;
    ptr_t  wptr;
    ptr_t  rptr;
    logic  oe_n;
  } core_s;

endpackage

// File: hdl/word_buffer2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock; producer and consumer on that clock.
// Notes:   Full refuses a push; the producer must hold its word.
`timescale 1ns/100ps
`default_nettype none

module word_buffer2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic                  wr_idx;
    logic                  rd_idx;
    logic [1:0]            count;
  } buf_s;

  buf_s buf_ff;
  buf_s nxt_buf;
  logic push;
  logic pop;

  assign in_ready_out  = (buf_ff.count != 2'd2);
  assign out_valid_out = (buf_ff.count != 2'd0);
  assign out_data_out  = buf_ff.slot[buf_ff.rd_idx];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    nxt_buf = buf_ff;
    if (push) begin
      nxt_buf.slot[buf_ff.wr_idx] = in_data_in;
      nxt_buf.wr_idx              = ~buf_ff.wr_idx;
    end
    if (pop) begin
      nxt_buf.rd_idx = ~buf_ff.rd_idx;
    end
    nxt_buf.count = 2'(buf_ff.count + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_ff <= '0;
    end else begin
      buf_ff <= nxt_buf;
    end
  end

endmodule // word_buffer2

`default_nettype wire

// File: bench/pixel_sink.sv
// Purpose: Pixel consumer at the far side of the output stream.
// Assumes: Runs on the reference clock; stall_in holds off the handshake.
// Notes:   Every byte taken is queued for the bench to compare.
`timescale 1ns/100ps
`default_nettype none

module pixel_sink
  import line_buffer_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  stall_in,
  input  wire logic  valid_in,
  input  wire byte_t data_in,
  output logic       ready_out
);
  byte_t got[$];

  assign ready_out = !stall_in;

  // A byte counts as taken only on a completed handshake.
  always @(posedge clk_in) begin
    if (valid_in && ready_out) begin
      got.push_back(data_in);
    end
  end
endmodule // pixel_sink

`default_nettype wire

// File: bench/serial_line_buffer_tb.sv
// Purpose: Self-checking bench for the serial line buffer.
// Assumes: Pin clocks run nine reference cycles per cycle.
// Notes:   No wrap run; a full lap would eat most of the cycle budget.
`timescale 1ns/100ps
`default_nettype none

module serial_line_buffer_tb
  import line_buffer_pkg::*;
();
  logic  clk = 0, rst = 1, stall = 0, wr_clk = 0, wen_n = 1, wclr_n = 1;
  logic  rd_clk = 0, rden_n = 1, rclr_n = 1, oe_n, vld, rdy;
  byte_t wd = '0, rd, want_q[$];
  byte_t mem[int];
  int    wp = 5047, rp = 5047, fails = 0, comparisons = 0, seed = 32'h1137;

  always #5 clk = ~clk;

  serial_line_buffer serial_line_buffer_i (
    .ref_clk_in(clk), .rst_in(rst), .write_clock_in(wr_clk),
    .write_side_enable_n_in(wen_n), .write_pointer_clear_n_in(wclr_n),
    .write_data_in(wd), .read_clock_in(rd_clk), .output_side_enable_n_in(rden_n),
    .read_pointer_clear_n_in(rclr_n), .read_data_out(rd),
    .read_data_oe_n_out(oe_n), .read_data_valid_out(vld), .read_data_ready_in(rdy));

  pixel_sink pixel_sink_i (
    .clk_in(clk), .stall_in(stall), .valid_in(vld), .data_in(rd), .ready_out(rdy));

  function automatic int step(int p, logic clr_n);
    return !clr_n ? 0 : (p == 5047 ? 0 : p + 1);
  endfunction

  task automatic check(logic [7:0] seen, logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // One pin cycle on either port; the model only moves when enabled.
  task automatic cyc(bit w, logic en_n, logic clr_n);
    @(negedge clk);
    if (w) begin
      wen_n = en_n;
      wclr_n = clr_n;
      wd = byte_t'($random(seed));
      wr_clk = 1;
      if (!en_n) begin
        wp = step(wp, clr_n);
        mem[wp] = wd;
      end
    end else begin
      rden_n = en_n;
      rclr_n = clr_n;
      rd_clk = 1;
      if (!en_n) begin
        rp = step(rp, clr_n);
        want_q.push_back(mem[rp]);
      end
    end
    repeat (4) @(negedge clk);
    wr_clk = 0;
    rd_clk = 0;
    repeat (4) @(negedge clk);
  endtask

  // Both ports on one shared clock edge; the read takes the old byte of a shared location.
  task automatic dual(logic clr_n);
    @(negedge clk);
    wen_n = 0;
    wclr_n = clr_n;
    rden_n = 0;
    rclr_n = clr_n;
    wd = byte_t'($random(seed));
    wr_clk = 1;
    rd_clk = 1;
    rp = step(rp, clr_n);
    want_q.push_back(mem[rp]);
    wp = step(wp, clr_n);
    mem[wp] = wd;
    repeat (4) @(negedge clk);
    wr_clk = 0;
    rd_clk = 0;
    repeat (4) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    cyc(1, 0, 1);
    repeat (2) cyc(1, 0, 0);
    repeat (6) cyc(1, 0, 1);
    cyc(1, 1, 1);
    repeat (2) cyc(1, 0, 1);
    cyc(0, 0, 1);
    repeat (2) cyc(0, 0, 0);
    repeat (3) cyc(0, 0, 1);
    check(8'(oe_n), 8'h00);
    cyc(0, 1, 1);
    check(8'(oe_n), 8'h01);
    stall = 1;
    repeat (2) cyc(0, 0, 1);
    // With both entries held the third read cycle is dropped, so the model takes it back.
    cyc(0, 0, 1);
    rp = rp - 1;
    void'(want_q.pop_back());
    check(8'(vld), 8'h01);
    check(rd, want_q[want_q.size() - 2]);
    stall = 0;
    repeat (3) cyc(0, 0, 1);
    // Joint clears on a shared clock: the second pass returns the bytes of the first.
    repeat (2) begin
      dual(0);
      repeat (3) dual(1);
    end
    for (int i = 0; i < 50 && pixel_sink_i.got.size() < want_q.size(); i++) begin
      @(negedge clk);
    end
    check(8'(pixel_sink_i.got.size()), 8'(want_q.size()));
    foreach (want_q[i]) begin
      check(pixel_sink_i.got[i], want_q[i]);
    end
    complete_run();
  end
endmodule // serial_line_buffer_tb

`default_nettype wire
